// >>> design/ichb_fifo.sv
// Parameterised flip-flop FIFO with valid/ready on both sides.
`timescale 1ns/1ps
`default_nettype none
module ichb_fifo #(
   parameter int WIDTH = 28,
   parameter int DEPTH = 8
) (
   input wire logic clock,
   input wire logic rst_n,
   ichb_stream_if.snk wr,
   ichb_stream_if.src rd
);
   // ------------------------------------------------------------------
   // Storage and pointers
   // ------------------------------------------------------------------
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);

   logic [WIDTH-1:0] mem_q [DEPTH];   // Word storage.
   logic [WIDTH-1:0] mem_d [DEPTH];
   logic [PW-1:0] wrPtr_q, wrPtr_d;   // Next slot to write.
   logic [PW-1:0] rdPtr_q, rdPtr_d;   // Oldest word.
   logic [CW-1:0] count_q, count_d;   // Words held; full and empty follow from it.
   logic push;
   logic pop;

   // Wraps a pointer at the last slot, so depths that are not powers of two work.
   function automatic logic [PW-1:0] ptr_next(input logic [PW-1:0] p);
      ptr_next = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
   endfunction : ptr_next

   assign wr.ready = (count_q != CW'(DEPTH));
   assign rd.valid = (count_q != '0);
   assign rd.data = mem_q[rdPtr_q];
   assign push = wr.valid && wr.ready;
   assign pop = rd.valid && rd.ready;

   // Next pointer, count and storage values.
   always_comb begin
      mem_d = mem_q;
      if (push) begin
         mem_d[wrPtr_q] = wr.data;
      end
      wrPtr_d = push ? ptr_next(wrPtr_q) : wrPtr_q;
      rdPtr_d = pop ? ptr_next(rdPtr_q) : rdPtr_q;
      count_d = count_q + CW'(push) - CW'(pop);
   end

   // Control registers reset; the data words need no reset because empty hides them.
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         wrPtr_q <= '0;
         rdPtr_q <= '0;
         count_q <= '0;
      end else begin
         wrPtr_q <= wrPtr_d;
         rdPtr_q <= rdPtr_d;
         count_q <= count_d;
      end
   end

   // Word storage registers.
   always_ff @(posedge clock) begin
      mem_q <= mem_d;
   end

   a_fifo_full_stall: assert property (@(posedge clock) disable iff (!rst_n)
      (count_q == CW'(DEPTH) && !pop) |=> (count_q == CW'(DEPTH)))
      else $error("FIFO accepts a word while full.");

   a_fifo_count_track: assert property (@(posedge clock) disable iff (!rst_n)
      (push && !pop) |=> (count_q == $past(count_q) + CW'(1)))
      else $error("FIFO count did not follow a push.");

endmodule : ichb_fifo
`default_nettype wire

// >>> design/ichb_filter_stage.sv
// Inverse CIC precompensation and fixed 4x half-band interpolator for I and Q.
`timescale 1ns/1ps
`default_nettype none
module ichb_filter_stage #(
   parameter int FIFO_DEPTH = ichb_pkg::FIFO_DEPTH
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic inValid,
   output logic inReady,
   input wire logic [ichb_pkg::SAMPLE_W-1:0] inI,
   input wire logic [ichb_pkg::SAMPLE_W-1:0] inQ,
   input wire logic dacMode,
   input wire logic icicBypass,
   input wire logic [ichb_pkg::RATE_W-1:0] cicRate,
   output logic outValid,
   input wire logic outReady,
   output logic [ichb_pkg::SAMPLE_W-1:0] outI,
   output logic [ichb_pkg::SAMPLE_W-1:0] outQ
);
   // ------------------------------------------------------------------
   // Local widths and arithmetic helpers
   // ------------------------------------------------------------------
   localparam int SW = ichb_pkg::SAMPLE_W;
   localparam int AW = ichb_pkg::ACC_W;

   // Clamps an accumulator to the sample range; wrap-around would be far worse than clipping.
   function automatic ichb_pkg::ichb_smp_t sat_sample(input logic signed [AW-1:0] v);
      if (v > ichb_pkg::SAT_MAX) begin
         sat_sample = SW'(ichb_pkg::SAT_MAX);
      end else if (v < ichb_pkg::SAT_MIN) begin
         sat_sample = SW'(ichb_pkg::SAT_MIN);
      end else begin
         sat_sample = SW'(v);
      end
   endfunction : sat_sample

   // Three-tap symmetric inverse CIC; the side taps lift the band edge against CIC droop.
   function automatic ichb_pkg::ichb_smp_t icic_tap(
      input ichb_pkg::ichb_smp_t a,
      input ichb_pkg::ichb_smp_t b,
      input ichb_pkg::ichb_smp_t c,
      input logic rateTwo
   );
      logic signed [AW-1:0] ctr;
      logic signed [AW-1:0] side;
      logic signed [AW-1:0] acc;
      ctr = rateTwo ? AW'(ichb_pkg::ICIC_CTR_R2) : AW'(ichb_pkg::ICIC_CTR_RN);
      side = rateTwo ? AW'(ichb_pkg::ICIC_SIDE_R2) : AW'(ichb_pkg::ICIC_SIDE_RN);
      acc = ctr * AW'(b) + side * (AW'(a) + AW'(c)) + ichb_pkg::ICIC_ROUND;
      icic_tap = sat_sample(acc >>> ichb_pkg::ICIC_SHIFT);
   endfunction : icic_tap

   // Odd phase of a half-band interpolator; symmetric taps keep the phase linear.
   function automatic ichb_pkg::ichb_smp_t hb_odd(
      input ichb_pkg::ichb_smp_t a,
      input ichb_pkg::ichb_smp_t b,
      input ichb_pkg::ichb_smp_t c,
      input ichb_pkg::ichb_smp_t d
   );
      logic signed [AW-1:0] acc;
      acc = AW'(ichb_pkg::HB_OUTER) * (AW'(a) + AW'(d))
          + AW'(ichb_pkg::HB_INNER) * (AW'(b) + AW'(c)) + ichb_pkg::HB_ROUND;
      hb_odd = sat_sample(acc >>> ichb_pkg::HB_SHIFT);
   endfunction : hb_odd

   // ------------------------------------------------------------------
   // Input buffer
   // ------------------------------------------------------------------
   ichb_stream_if #(.WIDTH(2 * SW)) fifoIn ();   // Pairs entering the buffer.
   ichb_stream_if #(.WIDTH(2 * SW)) fifoOut ();  // Pairs leaving toward the filters.

   // Each buffer word is one whole I/Q pair, so one pair moves per word.
   assign fifoIn.valid = inValid;
   assign fifoIn.data = {inI, inQ};
   assign inReady = fifoIn.ready;

   ichb_fifo #(.WIDTH(2 * SW), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clock(clock),
      .rst_n(rst_n),
      .wr(fifoIn),
      .rd(fifoOut)
   );

   // ------------------------------------------------------------------
   // Sequencing: one pair in, four outputs out
   // ------------------------------------------------------------------
   ichb_pkg::ichb_state_t state_q, state_d;   // Waiting for a pair or emitting.
   logic [1:0] phase_q, phase_d;              // Output slot within the current pair.
   logic outValid_q, outValid_d;              // Output word is held.
   logic step;                                // Output register may load.
   logic advance;                             // A new output word is produced.
   logic pop;                                 // A pair leaves the buffer.
   logic icicOff;                             // Inverse CIC stage is bypassed.
   logic rateTwo;                             // Rate two coefficient set selected.

   assign step = !outValid_q || outReady;
   assign pop = step && (state_q == ichb_pkg::ICHB_IDLE) && fifoOut.valid;
   assign advance = pop || (step && (state_q == ichb_pkg::ICHB_RUN));
   assign fifoOut.ready = step && (state_q == ichb_pkg::ICHB_IDLE);
   assign icicOff = icicBypass || (cicRate == ichb_pkg::CIC_RATE_ONE);
   assign rateTwo = (cicRate == ichb_pkg::CIC_RATE_TWO);

   // Next state: a pop yields slot 0, then three more slots follow on the run.
   always_comb begin
      state_d = state_q;
      phase_d = phase_q;
      outValid_d = outValid_q;
      if (advance) begin
         outValid_d = 1'b1;
      end else if (outReady) begin
         outValid_d = 1'b0;
      end
      case (state_q)
         ichb_pkg::ICHB_IDLE: begin
            if (pop) begin
               state_d = ichb_pkg::ICHB_RUN;
               phase_d = ichb_pkg::PHASE_FIRST;
            end
         end
         ichb_pkg::ICHB_RUN: begin
            if (advance) begin
               phase_d = phase_q + 2'h1;
               if (phase_q == ichb_pkg::PHASE_LAST) begin
                  state_d = ichb_pkg::ICHB_IDLE;
                  phase_d = ichb_pkg::PHASE_RESET;
               end
            end
         end
         default: begin
            state_d = ichb_pkg::ICHB_IDLE;
            phase_d = ichb_pkg::PHASE_RESET;
         end
      endcase
   end

   // Sequencer registers.
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         state_q <= ichb_pkg::ICHB_IDLE;
         phase_q <= ichb_pkg::PHASE_RESET;
         outValid_q <= 1'b0;
      end else begin
         state_q <= state_d;
         phase_q <= phase_d;
         outValid_q <= outValid_d;
      end
   end

   // ------------------------------------------------------------------
   // Datapath, index 0 is I and index 1 is Q
   // ------------------------------------------------------------------
   ichb_pkg::ichb_smp_t icicLine_q [2][3];   // Inverse CIC taps, index 0 newest.
   ichb_pkg::ichb_smp_t icicLine_d [2][3];
   ichb_pkg::ichb_smp_t hb1_q [2][4];        // First half-band taps.
   ichb_pkg::ichb_smp_t hb1_d [2][4];
   ichb_pkg::ichb_smp_t hb2_q [2][4];        // Second half-band taps.
   ichb_pkg::ichb_smp_t hb2_d [2][4];
   ichb_pkg::ichb_smp_t odd1_q [2];          // First half-band odd output, kept for slot 2.
   ichb_pkg::ichb_smp_t odd1_d [2];
   ichb_pkg::ichb_smp_t out_q [2];           // Output words.
   ichb_pkg::ichb_smp_t out_d [2];
   ichb_pkg::ichb_smp_t icicY [2];           // Inverse CIC result for the popped pair.
   ichb_pkg::ichb_smp_t pairIn [2];          // Popped pair split into paths.

   assign pairIn[0] = fifoOut.data[2*SW-1:SW];
   assign pairIn[1] = fifoOut.data[SW-1:0];

   // Both paths run the same loop body, so coefficients and latency match exactly.
   always_comb begin
      for (int p = 0; p < 2; p++) begin
         icicLine_d[p] = icicLine_q[p];
         hb1_d[p] = hb1_q[p];
         hb2_d[p] = hb2_q[p];
         odd1_d[p] = odd1_q[p];
         out_d[p] = out_q[p];
         icicY[p] = pairIn[p];
         if (p == 1 && dacMode) begin
            // The Q path is held at zero rather than filtered, which also saves power.
            icicLine_d[p] = '{default: '0};
            hb1_d[p] = '{default: '0};
            hb2_d[p] = '{default: '0};
            odd1_d[p] = '0;
            out_d[p] = '0;
         end else if (pop) begin
            if (!icicOff) begin
               // The tap line only shifts when in use; a bypassed stage holds still.
               icicLine_d[p] = '{pairIn[p], icicLine_q[p][0], icicLine_q[p][1]};
               icicY[p] = icic_tap(icicLine_d[p][0], icicLine_d[p][1],
                                   icicLine_d[p][2], rateTwo);
            end
            hb1_d[p] = '{icicY[p], hb1_q[p][0], hb1_q[p][1], hb1_q[p][2]};
            odd1_d[p] = hb_odd(hb1_d[p][0], hb1_d[p][1], hb1_d[p][2], hb1_d[p][3]);
            hb2_d[p] = '{hb1_d[p][2], hb2_q[p][0], hb2_q[p][1], hb2_q[p][2]};
            out_d[p] = hb2_d[p][2];
         end else if (advance) begin
            case (phase_q)
               ichb_pkg::PHASE_FIRST, ichb_pkg::PHASE_LAST: begin
                  out_d[p] = hb_odd(hb2_q[p][0], hb2_q[p][1], hb2_q[p][2], hb2_q[p][3]);
               end
               default: begin
                  hb2_d[p] = '{odd1_q[p], hb2_q[p][0], hb2_q[p][1], hb2_q[p][2]};
                  out_d[p] = hb2_d[p][2];
               end
            endcase
         end
      end
   end

   // Datapath registers; reset flushes all tap lines with zeros.
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         icicLine_q <= '{default: '{default: '0}};
         hb1_q <= '{default: '{default: '0}};
         hb2_q <= '{default: '{default: '0}};
         odd1_q <= '{default: '0};
         out_q <= '{default: '0};
      end else begin
         icicLine_q <= icicLine_d;
         hb1_q <= hb1_d;
         hb2_q <= hb2_d;
         odd1_q <= odd1_d;
         out_q <= out_d;
      end
   end

   assign outValid = outValid_q;
   assign outI = out_q[0];
   assign outQ = out_q[1];

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   a_bypass_manual: assert property (@(posedge clock) disable iff (!rst_n)
      (pop && icicBypass) |-> (icicY[0] == pairIn[0]))
      else $error("Inverse CIC altered data while bypassed by control bit.");

   a_bypass_rate_one: assert property (@(posedge clock) disable iff (!rst_n)
      (pop && cicRate == ichb_pkg::CIC_RATE_ONE) |-> (icicY[0] == pairIn[0]))
      else $error("Inverse CIC altered data at CIC rate one.");

   a_icic_frozen: assert property (@(posedge clock) disable iff (!rst_n)
      icicOff |=> ($stable(icicLine_q[0][0]) && $stable(icicLine_q[0][2])))
      else $error("Bypassed inverse CIC taps toggled.");

   // An active stage must shift its taps on every pair; a stuck line would still pass DC.
   a_icic_shift: assert property (@(posedge clock) disable iff (!rst_n)
      (pop && !icicOff) |=> (icicLine_q[0][1] == $past(icicLine_q[0][0])))
      else $error("Active inverse CIC taps did not shift on a pair.");

   // The first half-band takes one new sample per pair, whatever the bypass setting.
   a_hb1_shift: assert property (@(posedge clock) disable iff (!rst_n)
      pop |=> (hb1_q[0][1] == $past(hb1_q[0][0])))
      else $error("First half-band taps did not shift on a pair.");

   a_pop_first_slot: assert property (@(posedge clock) disable iff (!rst_n)
      pop |=> (state_q == ichb_pkg::ICHB_RUN && phase_q == ichb_pkg::PHASE_FIRST))
      else $error("A popped pair did not start a four-slot run.");

   // The fourth slot must hand the sequencer back to idle with its word still held.
   a_four_outputs: assert property (@(posedge clock) disable iff (!rst_n)
      (advance && state_q == ichb_pkg::ICHB_RUN && phase_q == ichb_pkg::PHASE_LAST)
      |=> (state_q == ichb_pkg::ICHB_IDLE && phase_q == ichb_pkg::PHASE_RESET && outValid_q))
      else $error("Run did not end after the fourth output.");

   // The even slot of a pair is the old middle tap, moved one place down the line.
   a_even_center: assert property (@(posedge clock) disable iff (!rst_n)
      pop |=> (outI == $past(hb2_q[0][1])))
      else $error("Even output is not the centre tap of the second half-band.");

   a_q_silent: assert property (@(posedge clock) disable iff (!rst_n)
      $past(dacMode) |-> (outQ == '0))
      else $error("Q path carried data in interpolating DAC mode.");

   a_out_hold: assert property (@(posedge clock) disable iff (!rst_n)
      (outValid_q && !outReady) |=> (outValid_q && $stable(outI) && $stable(outQ)))
      else $error("Output changed while stalled.");

endmodule : ichb_filter_stage
`default_nettype wire

// >>> design/ichb_pkg.sv
// Shared constants and types for the inverse CIC and half-band interpolator stage.
package ichb_pkg;

   // ------------------------------------------------------------------
   // Data widths
   // ------------------------------------------------------------------
   localparam int SAMPLE_W = 14;      // Two's complement sample width on each path.
   localparam int ACC_W = 24;         // Accumulator width inside the filter arithmetic.
   localparam int RATE_W = 6;         // Width of the CIC interpolation rate setting.
   localparam int FIFO_DEPTH = 8;     // Words of input buffering in front of the filters.

   typedef logic signed [SAMPLE_W-1:0] ichb_smp_t;

   // ------------------------------------------------------------------
   // Inverse CIC coefficients (scaled by 2^10), one set per CIC rate class
   // ------------------------------------------------------------------
   localparam int ICIC_SHIFT = 10;
   localparam logic signed [ACC_W-1:0] ICIC_ROUND = 24'sh000200;
   localparam logic signed [11:0] ICIC_CTR_R2 = 12'sh3e4;   // DC gain about -0.5 dB.
   localparam logic signed [11:0] ICIC_SIDE_R2 = 12'shff2;
   localparam logic signed [11:0] ICIC_CTR_RN = 12'sh3d3;   // DC gain about -0.8 dB.
   localparam logic signed [11:0] ICIC_SIDE_RN = 12'shfea;

   // ------------------------------------------------------------------
   // Half-band odd phase taps (scaled by 2^4), symmetric
   // ------------------------------------------------------------------
   localparam int HB_SHIFT = 4;
   localparam logic signed [ACC_W-1:0] HB_ROUND = 24'sh000008;
   localparam logic signed [11:0] HB_OUTER = 12'shfff;
   localparam logic signed [11:0] HB_INNER = 12'sh009;

   // ------------------------------------------------------------------
   // Saturation limits and control encodings
   // ------------------------------------------------------------------
   localparam logic signed [ACC_W-1:0] SAT_MAX = 24'sh001fff;
   localparam logic signed [ACC_W-1:0] SAT_MIN = 24'shffe000;
   localparam logic [RATE_W-1:0] CIC_RATE_ONE = 6'h01;
   localparam logic [RATE_W-1:0] CIC_RATE_TWO = 6'h02;
   localparam logic [1:0] PHASE_RESET = 2'h0;
   localparam logic [1:0] PHASE_FIRST = 2'h1;
   localparam logic [1:0] PHASE_LAST = 2'h3;

   typedef enum logic [1:0] {
      ICHB_IDLE = 2'b01,   // Waiting for the next I/Q pair.
      ICHB_RUN = 2'b10     // Emitting the remaining three outputs of a pair.
   } ichb_state_t;

endpackage : ichb_pkg

// >>> design/ichb_stream_if.sv
// Valid/ready stream carrier between the filter stage and its input buffer.
`timescale 1ns/1ps
`default_nettype none
interface ichb_stream_if #(
   parameter int WIDTH = 28
) ();
   logic valid;               // Producer holds a word.
   logic ready;               // Consumer takes it this cycle.
   logic [WIDTH-1:0] data;    // The word itself.
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface : ichb_stream_if
`default_nettype wire

// >>> sim/ichb_partner.sv
// Far-side model: the pair source in front of the stage and a sink behind it that can stall.
`timescale 1ns/1ps
`default_nettype none
module ichb_partner (
   input wire logic clock,
   input wire logic rst_n,
   output logic inValid,
   input wire logic inReady,
   output logic [ichb_pkg::SAMPLE_W-1:0] inI,
   output logic [ichb_pkg::SAMPLE_W-1:0] inQ,
   input wire logic outValid,
   output logic outReady,
   input wire logic [ichb_pkg::SAMPLE_W-1:0] outI,
   input wire logic [ichb_pkg::SAMPLE_W-1:0] outQ,
   input wire logic [1:0] sinkMode
);
   // ---------------------------------------------------------------
   // Queues of pending pairs and of collected output words
   // ---------------------------------------------------------------
   logic [ichb_pkg::SAMPLE_W-1:0] srcI[$];  // Pairs not yet taken, I half.
   logic [ichb_pkg::SAMPLE_W-1:0] srcQ[$];  // Pairs not yet taken, Q half.
   logic [ichb_pkg::SAMPLE_W-1:0] gotI[$];  // Output words seen, I half.
   logic [ichb_pkg::SAMPLE_W-1:0] gotQ[$];  // Output words seen, Q half.

   // Queues one pair; the bench feeds DC levels and a single impulse.
   task automatic send(input logic [ichb_pkg::SAMPLE_W-1:0] i,
                       input logic [ichb_pkg::SAMPLE_W-1:0] q);
      srcI.push_back(i);
      srcQ.push_back(q);
   endtask : send

   // Number of pairs still waiting to be taken.
   function automatic int pending();
      return srcI.size();
   endfunction : pending

   // Forgets every collected word before a new scenario.
   task automatic clear_sink();
      gotI.delete();
      gotQ.delete();
   endtask : clear_sink

   initial begin
      inValid = 1'b0;
      inI = '0;
      inQ = '0;
      outReady = 1'b0;
   end

   // ---------------------------------------------------------------
   // Source and sink, both changing only just after the rising edge
   // ---------------------------------------------------------------
   // A pair is held until taken; while no pair is queued the data lines toggle every
   // cycle, so a stale value can never pass for a fresh one.
   always @(posedge clock) begin
      if (!rst_n) begin
         inValid <= 1'b0;
         outReady <= 1'b0;
      end else begin
         if (inValid && inReady) begin
            srcI.delete(0);
            srcQ.delete(0);
         end
         if (srcI.size() > 0) begin
            inValid <= 1'b1;
            inI <= srcI[0];
            inQ <= srcQ[0];
         end else begin
            inValid <= 1'b0;
            inI <= ~inI;
            inQ <= ~inQ;
         end
         if (outValid && outReady) begin
            gotI.push_back(outI);
            gotQ.push_back(outQ);
         end
         // Mode 0 answers at once, 1 every other cycle, 2 stalls outright.
         case (sinkMode)
            2'h0: outReady <= 1'b1;
            2'h1: outReady <= ~outReady;
            default: outReady <= 1'b0;
         endcase
      end
   end
endmodule : ichb_partner
`default_nettype wire

// >>> sim/inverse_cic_and_halfband_interp_tb_top.sv
// Self-checking bench for the inverse CIC and fixed 4x half-band stage.
`timescale 1ns/1ps
`default_nettype none
`define ICHB_CHK(got, exp) \
   begin \
      check_count++; \
      if ((got) !== (exp)) begin \
         err_count++; \
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp); \
      end \
   end
module inverse_cic_and_halfband_interp_tb_top;
   // ---------------------------------------------------------------
   // Stimulus and observation signals
   // ---------------------------------------------------------------
   logic clock;
   logic rst_n;
   logic inValid;
   logic inReady;
   logic [ichb_pkg::SAMPLE_W-1:0] inI;
   logic [ichb_pkg::SAMPLE_W-1:0] inQ;
   logic dacMode;
   logic icicBypass;
   logic [ichb_pkg::RATE_W-1:0] cicRate;
   logic outValid;
   logic outReady;
   logic [ichb_pkg::SAMPLE_W-1:0] outI;
   logic [ichb_pkg::SAMPLE_W-1:0] outQ;
   logic [1:0] sinkMode;  // Pace of the downstream sink.
   int err_count;         // Mismatches seen.
   int check_count;       // Comparisons made.

   ichb_filter_stage #(.FIFO_DEPTH(8)) ichb_filter_stage_inst (
      .clock(clock), .rst_n(rst_n), .inValid(inValid), .inReady(inReady), .inI(inI),
      .inQ(inQ), .dacMode(dacMode), .icicBypass(icicBypass), .cicRate(cicRate),
      .outValid(outValid), .outReady(outReady), .outI(outI), .outQ(outQ)
   );

   ichb_partner ichb_partner_inst (
      .clock(clock), .rst_n(rst_n), .inValid(inValid), .inReady(inReady), .inI(inI),
      .inQ(inQ), .outValid(outValid), .outReady(outReady), .outI(outI), .outQ(outQ),
      .sinkMode(sinkMode)
   );

   // ---------------------------------------------------------------
   // Shared helpers
   // ---------------------------------------------------------------
   // Expected DC level after precompensation; the sum of taps over 1024.
   function automatic ichb_pkg::ichb_smp_t dc_gain(input int val, input int num);
      return ichb_pkg::ichb_smp_t'((val * num + 512) >>> 10);
   endfunction : dc_gain

   // Controls change only between pairs, while the stage is drained.
   task automatic set_ctrl(input logic byp, input logic [5:0] rate, input logic dac);
      @(posedge clock);
      icicBypass <= byp;
      cicRate <= rate;
      dacMode <= dac;
      ichb_partner_inst.clear_sink();
   endtask : set_ctrl

   // Waits for n words, then a little longer so that surplus words show up.
   task automatic collect(input int n);
      int waited;
      waited = 0;
      while (ichb_partner_inst.gotI.size() < n && waited < 4000) begin
         @(posedge clock);
         waited++;
      end
      repeat (8) @(posedge clock);
      `ICHB_CHK(ichb_partner_inst.gotI.size(), n)
   endtask : collect

   // Eight equal pairs settle every tap line; the last four words are checked.
   task automatic run_dc(input ichb_pkg::ichb_smp_t val, input logic byp, input logic [5:0] rate,
                         input logic dac, input ichb_pkg::ichb_smp_t expI);
      ichb_pkg::ichb_smp_t expQ;
      expQ = dac ? ichb_pkg::ichb_smp_t'(0) : ichb_pkg::ichb_smp_t'(-expI);
      set_ctrl(byp, rate, dac);
      for (int k = 0; k < 8; k++) begin
         ichb_partner_inst.send(val, -val);
      end
      collect(32);
      for (int k = 28; k < 32; k++) begin
         `ICHB_CHK(ichb_partner_inst.gotI[k], expI)
         `ICHB_CHK(ichb_partner_inst.gotQ[k], expQ)
      end
   endtask : run_dc

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   // Both bypass causes must pass the level through untouched.
   task automatic tc_bypass();
      run_dc(4096, 1'b1, 6'h05, 1'b0, 4096);
      run_dc(-4096, 1'b0, 6'h01, 1'b0, -4096);
   endtask : tc_bypass

   // Rate two uses its own taps; every rate other than one and two, the top one too, the other set.
   task automatic tc_rate_taps();
      run_dc(4096, 1'b0, 6'h02, 1'b0, dc_gain(4096, 968));
      run_dc(-4096, 1'b0, 6'h02, 1'b0, dc_gain(-4096, 968));
      run_dc(4096, 1'b0, 6'h03, 1'b0, dc_gain(4096, 935));
      run_dc(-4096, 1'b0, 6'h3f, 1'b0, dc_gain(-4096, 935));
   endtask : tc_rate_taps

   // Interpolating DAC mode keeps Q at zero, under a slow sink.
   task automatic tc_dac_mode();
      sinkMode <= 2'h1;
      run_dc(4096, 1'b0, 6'h03, 1'b1, dc_gain(4096, 935));
      sinkMode <= 2'h0;
   endtask : tc_dac_mode

   // An impulse shows gain, symmetry and equal I/Q latency in one run.
   task automatic tc_impulse();
      int f;
      int l;
      int sum;
      f = -1;
      l = -1;
      sum = 0;
      // A mid-run reset flushes the levels that earlier scenarios left in the tap lines.
      @(posedge clock);
      rst_n <= 1'b0;
      repeat (2) @(posedge clock);
      rst_n <= 1'b1;
      set_ctrl(1'b1, 6'h01, 1'b0);
      ichb_partner_inst.send(14'h0400, 14'h3c00);
      for (int k = 0; k < 7; k++) begin
         ichb_partner_inst.send(14'h0000, 14'h0000);
      end
      collect(32);
      for (int k = 0; k < 32; k++) begin
         `ICHB_CHK(ichb_partner_inst.gotQ[k], -ichb_partner_inst.gotI[k])
         sum += int'(ichb_pkg::ichb_smp_t'(ichb_partner_inst.gotI[k]));
         if (ichb_partner_inst.gotI[k] !== '0) begin
            if (f < 0) begin
               f = k;
            end
            l = k;
         end
      end
      // Four outputs per input, each stage of unity DC gain: the sum is four times 1024.
      `ICHB_CHK(sum, 4096)
      if (f >= 0) begin
         for (int j = 0; j <= (l - f) / 2; j++) begin
            `ICHB_CHK(ichb_partner_inst.gotI[f + j], ichb_partner_inst.gotI[l - j])
         end
      end
   endtask : tc_impulse

   // A stalled sink fills the buffer until it refuses; then it drains at half pace.
   task automatic tc_backpressure();
      int taken;
      set_ctrl(1'b1, 6'h01, 1'b0);
      sinkMode <= 2'h2;
      for (int k = 0; k < 12; k++) begin
         ichb_partner_inst.send(14'h0800, 14'h0800);
      end
      repeat (30) @(posedge clock);
      #1;
      taken = 12 - ichb_partner_inst.pending();
      `ICHB_CHK(inReady, 1'b0)
      `ICHB_CHK(taken >= 8 && taken <= 10, 1'b1)
      @(posedge clock);
      sinkMode <= 2'h1;
      collect(48);
      `ICHB_CHK(ichb_partner_inst.gotI[47], 14'h0800)
      sinkMode <= 2'h0;
   endtask : tc_backpressure

   // ---------------------------------------------------------------
   // Clock, sequence, watchdog and verdict
   // ---------------------------------------------------------------
   task automatic test_done();
      $display("Comparisons: %0d, mismatches: %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : test_done

   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end

   // The whole sequence needs well under 2000 cycles; this limit catches a hang.
   initial begin
      repeat (20000) @(posedge clock);
      err_count++;
      test_done();
   end

   initial begin
      rst_n = 1'b0;
      dacMode = 1'b0;
      icicBypass = 1'b0;
      cicRate = 6'h02;
      sinkMode = 2'h0;
      err_count = 0;
      check_count = 0;
      repeat (3) @(posedge clock);
      #1;
      `ICHB_CHK(outValid, 1'b0)
      `ICHB_CHK(inReady, 1'b1)
      @(posedge clock);
      rst_n <= 1'b1;
      tc_bypass();
      tc_rate_taps();
      tc_dac_mode();
      tc_impulse();
      tc_backpressure();
      test_done();
   end
endmodule : inverse_cic_and_halfband_interp_tb_top
`default_nettype wire
